// ==== src/sofs_pkg.sv ====
// Constants for the status output function selector
package sofs_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [3:0] ADDR_DUAL_TERMINAL_MODE_SELECT = 4'h0;
   localparam logic [3:0] ADDR_OPEN_COLLECTOR_FUNCTION_SELECT = 4'h1;
   localparam logic [3:0] ADDR_RELAY_FUNCTION_SELECT = 4'h2;
   localparam logic [3:0] ADDR_DUAL_TERMINAL_FUNCTION_SELECT = 4'h3;
   localparam logic [3:0] ADDR_PULSE_PERIOD = 4'h4;
   localparam logic [3:0] ADDR_OUTPUT_STATUS = 4'h5;
   localparam int REG_WIDTH = 16;
   localparam logic [15:0] RST_MODE = 16'h0000;
   localparam logic [15:0] RST_OPEN_COLLECTOR = 16'h0000;
   localparam logic [15:0] RST_RELAY = 16'h0002;
   localparam logic [15:0] RST_DUAL_FUNCTION = 16'h0000;
   localparam logic [15:0] RST_PULSE_PERIOD = 16'h0064;
   // ----------------------------------------
   // Codes and limits
   // ----------------------------------------
   localparam logic [15:0] MODE_MAX = 16'h0001;
   localparam logic [15:0] MODE_PULSE = 16'h0000;
   localparam logic [15:0] OPEN_COLLECTOR_MAX = 16'h0026;
   localparam logic [15:0] RELAY_MAX = 16'h001e;
   localparam logic [15:0] IMPLEMENTED_MAX = 16'h0012;
   localparam int NUM_OUTPUTS = 3;
   localparam int NUM_CODES = 19;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam longint CLK_HZ = 10000000;
   localparam longint PULSE_MAX_HZ = 100000;
   localparam logic [15:0] PULSE_MIN_PERIOD = 16'((CLK_HZ + PULSE_MAX_HZ - 1) / PULSE_MAX_HZ);
   localparam longint CYCLE_PULSE_MS = 250;
   localparam int CYCLE_PULSE_CYCLES = int'((CLK_HZ * CYCLE_PULSE_MS) / 1000);
endpackage

// ==== src/sofs_top.sv ====
// Status output function selector: register file, code table and output drivers
`timescale 1ns/1ps
module sofs_top
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic drive_running,
   input wire logic output_freq_zero,
   input wire logic fault_stop,
   input wire logic freq_level_detect,
   input wire logic freq_arrival,
   input wire logic motor_overload_prealarm,
   input wire logic drive_overload_prealarm,
   input wire logic set_count_reached,
   input wire logic designated_count_reached,
   input wire logic length_reached,
   input wire logic sequence_cycle_done,
   input wire logic running_time_reached,
   input wire logic set_freq_beyond_limit,
   input wire logic output_freq_at_limit,
   input wire logic speed_control_mode,
   input wire logic torque_at_limit,
   input wire logic supplies_stable,
   input wire logic fault_detected,
   input wire logic run_permitted,
   input wire logic [15:0] analog_input_first,
   input wire logic [15:0] analog_input_second,
   input wire logic freq_at_upper_limit,
   input wire logic freq_at_lower_limit,
   output logic open_collector_on,
   output logic relay_contacts,
   output logic dual_terminal_switch_output,
   output logic pulse_train_output,
   output logic dual_terminal_pulse_mode
);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [15:0] mode_q;
   logic [15:0] mode_d;
   logic [15:0] oc_sel_q;
   logic [15:0] relay_sel_q;
   logic [15:0] dual_sel_q;
   logic [15:0] period_q;
   logic [sofs_pkg::NUM_OUTPUTS-1:0] out_q;
   logic [15:0] status_word;

   assign status_word = {13'h0000, out_q};

   // ----------------------------------------
   // Write decode
   // ----------------------------------------
   logic wr_mode;
   logic wr_oc;
   logic wr_relay;
   logic wr_dual;
   logic wr_period;

   always_comb
   begin
      wr_mode = 1'b0;
      wr_oc = 1'b0;
      wr_relay = 1'b0;
      wr_dual = 1'b0;
      wr_period = 1'b0;
      if (!(clk_en && reg_wr))
         wr_mode = 1'b0;
      else if (reg_addr == sofs_pkg::ADDR_DUAL_TERMINAL_MODE_SELECT)
         wr_mode = 1'b1;
      else if (reg_addr == sofs_pkg::ADDR_OPEN_COLLECTOR_FUNCTION_SELECT)
         wr_oc = 1'b1;
      else if (reg_addr == sofs_pkg::ADDR_RELAY_FUNCTION_SELECT)
         wr_relay = 1'b1;
      else if (reg_addr == sofs_pkg::ADDR_DUAL_TERMINAL_FUNCTION_SELECT)
         wr_dual = 1'b1;
      else if (reg_addr == sofs_pkg::ADDR_PULSE_PERIOD)
         wr_period = 1'b1;
   end

   // ----------------------------------------
   // Selector registers
   // ----------------------------------------
   // Writes above the allowed range are dropped, old code kept
   always_comb
   begin
      mode_d = mode_q;
      if (wr_mode && reg_wdata <= sofs_pkg::MODE_MAX)
         mode_d = reg_wdata;
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         mode_q <= sofs_pkg::RST_MODE;
      else
         mode_q <= mode_d;
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         oc_sel_q <= sofs_pkg::RST_OPEN_COLLECTOR;
      else if (wr_oc && reg_wdata <= sofs_pkg::OPEN_COLLECTOR_MAX)
         oc_sel_q <= reg_wdata;
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         relay_sel_q <= sofs_pkg::RST_RELAY;
      else if (wr_relay && reg_wdata <= sofs_pkg::RELAY_MAX)
         relay_sel_q <= reg_wdata;
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         dual_sel_q <= sofs_pkg::RST_DUAL_FUNCTION;
      else if (wr_dual && reg_wdata <= sofs_pkg::OPEN_COLLECTOR_MAX)
         dual_sel_q <= reg_wdata;
   end

   // ----------------------------------------
   // Pulse period register
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         period_q <= sofs_pkg::RST_PULSE_PERIOD;
      else if (wr_period)
      begin
         // Period below the minimum would exceed the top pulse rate
         if (reg_wdata < sofs_pkg::PULSE_MIN_PERIOD)
            period_q <= sofs_pkg::PULSE_MIN_PERIOD;
         else
            period_q <= reg_wdata;
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   logic [15:0] rd_word;

   // Unmapped offsets read as zero
   always_comb
   begin
      rd_word = 16'h0000;
      if (reg_addr == sofs_pkg::ADDR_DUAL_TERMINAL_MODE_SELECT)
         rd_word = mode_q;
      else if (reg_addr == sofs_pkg::ADDR_OPEN_COLLECTOR_FUNCTION_SELECT)
         rd_word = oc_sel_q;
      else if (reg_addr == sofs_pkg::ADDR_RELAY_FUNCTION_SELECT)
         rd_word = relay_sel_q;
      else if (reg_addr == sofs_pkg::ADDR_DUAL_TERMINAL_FUNCTION_SELECT)
         rd_word = dual_sel_q;
      else if (reg_addr == sofs_pkg::ADDR_PULSE_PERIOD)
         rd_word = period_q;
      else if (reg_addr == sofs_pkg::ADDR_OUTPUT_STATUS)
         rd_word = status_word;
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         reg_rdata <= 16'h0000;
      else if (clk_en)
      begin
         if (reg_rd)
            reg_rdata <= rd_word;
         else
            reg_rdata <= 16'h0000;
      end
   end

   // ----------------------------------------
   // Sequence cycle pulse stretcher
   // ----------------------------------------
   logic [$clog2(sofs_pkg::CYCLE_PULSE_CYCLES+1)-1:0] cyc_cnt_q;
   logic cyc_pulse;

   // A new cycle end during the pulse restarts it rather than stacking
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         cyc_cnt_q <= '0;
      else if (clk_en)
      begin
         if (sequence_cycle_done)
            cyc_cnt_q <= ($bits(cyc_cnt_q))'(sofs_pkg::CYCLE_PULSE_CYCLES);
         else if (cyc_cnt_q != '0)
            cyc_cnt_q <= cyc_cnt_q - 1'b1;
      end
   end

   assign cyc_pulse = (cyc_cnt_q != '0);

   // ----------------------------------------
   // Common code table
   // ----------------------------------------
   logic [sofs_pkg::NUM_CODES-1:0] cond;

   always_comb
   begin
      cond = '0;
      cond[0] = 1'b0;
      cond[1] = drive_running;
      cond[2] = fault_stop;
      cond[3] = freq_level_detect;
      cond[4] = freq_arrival;
      cond[5] = drive_running && output_freq_zero;
      cond[6] = motor_overload_prealarm;
      cond[7] = drive_overload_prealarm;
      cond[8] = set_count_reached;
      cond[9] = designated_count_reached;
      cond[10] = length_reached;
      cond[11] = cyc_pulse;
      cond[12] = running_time_reached;
      cond[13] = set_freq_beyond_limit && output_freq_at_limit;
      cond[14] = speed_control_mode && torque_at_limit;
      cond[15] = supplies_stable && !fault_detected && run_permitted;
      cond[16] = analog_input_first > analog_input_second;
      cond[17] = freq_at_upper_limit;
      cond[18] = drive_running && freq_at_lower_limit;
   end

   // ----------------------------------------
   // Per-output selection
   // ----------------------------------------
   logic [15:0] sel [sofs_pkg::NUM_OUTPUTS];
   logic [sofs_pkg::NUM_OUTPUTS-1:0] out_d;

   assign sel[0] = oc_sel_q;
   assign sel[1] = relay_sel_q;
   assign sel[2] = dual_sel_q;

   // Same table, independent selectors; codes past 18 are not wired and read inactive
   genvar g;
   generate
      for (g = 0; g < sofs_pkg::NUM_OUTPUTS; g++)
      begin : g_out
         assign out_d[g] = (sel[g] > sofs_pkg::IMPLEMENTED_MAX) ? 1'b0 : cond[sel[g][4:0]];
         always_ff @(posedge ref_clk or negedge rst_b)
         begin
            if (!rst_b)
               out_q[g] <= 1'b0;
            else if (clk_en)
               out_q[g] <= out_d[g];
         end
      end
   endgenerate

   // ----------------------------------------
   // Pulse train generator
   // ----------------------------------------
   logic pulse_mode;
   logic [15:0] div_q;
   logic half_done;
   logic pulse_q;

   assign pulse_mode = (mode_q == sofs_pkg::MODE_PULSE);

   // Square wave: toggles twice per period, so period counts halves
   assign half_done = (div_q >= (period_q >> 1) - 16'h0001);

   // Counter restarts whenever the terminal leaves pulse mode
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         div_q <= 16'h0000;
      else if (clk_en)
      begin
         if (!pulse_mode || half_done)
            div_q <= 16'h0000;
         else
            div_q <= div_q + 16'h0001;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         pulse_q <= 1'b0;
      else if (clk_en)
      begin
         if (!pulse_mode)
            pulse_q <= 1'b0;
         else if (half_done)
            pulse_q <= ~pulse_q;
      end
   end

   // ----------------------------------------
   // Dual terminal switch drive
   // ----------------------------------------
   logic dsw_q;

   // Built from the next mode so the pin changes in the same cycle as the mode register
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         dsw_q <= 1'b0;
      else if (clk_en)
         dsw_q <= out_d[2] && (mode_d != sofs_pkg::MODE_PULSE);
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign open_collector_on = out_q[0];
   assign relay_contacts = out_q[1];
   assign dual_terminal_switch_output = dsw_q;
   assign pulse_train_output = pulse_q;
   assign dual_terminal_pulse_mode = pulse_mode;

endmodule // sofs_top

// ==== tb/sofs_bench.sv ====
// Self-checking bench for the status output function selector
`timescale 1ns/1ps
module sofs_bench;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic clk_en = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic [20:0] st = '0;
   logic [15:0] ai1 = 16'h0000;
   logic [15:0] ai2 = 16'h0000;
   logic oc, rl, dsw, ptr, pmode, seq_q, eoc, erl, eds;
   logic [15:0] oc_s, rl_s, ds_s, mode_s;
   logic [31:0] r;
   int errors = 0;
   int samples_checked = 0;
   int cyc = 0;
   int min_gap, toggles;
   sofs_top dut (.ref_clk, .rst_b, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .drive_running(st[0]), .output_freq_zero(st[1]), .fault_stop(st[2]), .freq_level_detect(st[3]),
      .freq_arrival(st[4]), .motor_overload_prealarm(st[5]), .drive_overload_prealarm(st[6]),
      .set_count_reached(st[7]), .designated_count_reached(st[8]), .length_reached(st[9]),
      .sequence_cycle_done(st[10]), .running_time_reached(st[11]), .set_freq_beyond_limit(st[12]),
      .output_freq_at_limit(st[13]), .speed_control_mode(st[14]), .torque_at_limit(st[15]),
      .supplies_stable(st[16]), .fault_detected(st[17]), .run_permitted(st[18]), .freq_at_upper_limit(st[19]),
      .freq_at_lower_limit(st[20]), .analog_input_first(ai1), .analog_input_second(ai2), .open_collector_on(oc),
      .relay_contacts(rl), .dual_terminal_switch_output(dsw), .pulse_train_output(ptr),
      .dual_terminal_pulse_mode(pmode));
   sofs_load u_load (.ref_clk, .rst_b, .pulse_in(ptr), .min_gap, .toggles);
   initial forever #50 ref_clk = ~ref_clk;
   // ----------------------------------------
   // Reference model and checks
   // ----------------------------------------
   function automatic logic pick(input logic [15:0] c, input logic [20:0] s, input logic q);
      logic [18:0] v;
      v = {s[0] & s[20], s[19], ai1 > ai2, s[16] & !s[17] & s[18], s[14] & s[15], s[12] & s[13], s[11], q,
         s[9], s[8], s[7], s[6], s[5], s[0] & s[1], s[4], s[3], s[2], s[0], 1'b0};
      return (c < 16'h0013) ? v[c[4:0]] : 1'b0;
   endfunction
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   always @(posedge ref_clk or negedge rst_b)
      if (!rst_b)
      begin
         {oc_s, ds_s, mode_s, seq_q, eoc, erl, eds} <= '0;
         rl_s <= 16'h0002;
      end
      else if (clk_en)
      begin
         eoc <= pick(oc_s, st, seq_q);
         erl <= pick(rl_s, st, seq_q);
         eds <= pick(ds_s, st, seq_q);
         seq_q <= seq_q | st[10];
         if (reg_wr && reg_addr == 4'h0 && reg_wdata <= 16'h0001) mode_s <= reg_wdata;
         if (reg_wr && reg_addr == 4'h1 && reg_wdata <= 16'h0026) oc_s <= reg_wdata;
         if (reg_wr && reg_addr == 4'h2 && reg_wdata <= 16'h001e) rl_s <= reg_wdata;
         if (reg_wr && reg_addr == 4'h3 && reg_wdata <= 16'h0026) ds_s <= reg_wdata;
      end
   always @(posedge ref_clk)
   begin
      if (cyc == 0)
         r = $urandom(58);
      r = $urandom;
      st <= 21'(r);
      r = $urandom;
      ai1 <= r[15:0];
      ai2 <= r[15:0] ^ {14'h0, r[17:16]};
      cyc++;
      if (cyc == 6000)
      begin
         errors++;
         tally_and_finish();
      end
   end
   always @(negedge ref_clk)
      if (rst_b)
      begin
         cmp(16'(oc), 16'(eoc));
         cmp(16'(rl), 16'(erl));
         cmp(16'(dsw), 16'(eds & mode_s[0]));
         cmp(16'(pmode), 16'(!mode_s[0]));
      end
   // ----------------------------------------
   // Register bus and main sequence
   // ----------------------------------------
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      cmp(reg_rdata, e);
   endtask
   task automatic tally_and_finish();
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      repeat (6) @(posedge ref_clk);
      rst_b <= 1'b1;
      rd(4'h0, 16'h0000);
      rd(4'h1, 16'h0000);
      rd(4'h2, 16'h0002);
      rd(4'hc, 16'h0000);
      // A too short period must be clamped, not obeyed
      wr(4'h4, 16'h000a);
      rd(4'h4, 16'h0064);
      repeat (800) @(posedge ref_clk);
      cmp(16'(min_gap >= 50 && toggles > 4), 16'h0001);
      wr(4'h0, 16'h0002);
      rd(4'h0, 16'h0000);
      wr(4'h0, 16'h0001);
      for (int c = 0; c < 41; c++)
      begin
         wr(4'h1, 16'(c));
         wr(4'h2, 16'(c));
         wr(4'h3, 16'(c));
         repeat (25) @(posedge ref_clk);
         rd(4'h1, oc_s);
         rd(4'h2, rl_s);
         rd(4'h3, ds_s);
      end
      // A write made while the clock enable is low must be swallowed
      @(posedge ref_clk);
      clk_en <= 1'b0;
      wr(4'h1, 16'h0001);
      clk_en <= 1'b1;
      rd(4'h1, 16'h0026);
      tally_and_finish();
   end
endmodule // sofs_bench

// ==== tb/sofs_load.sv ====
// Load on the pulse terminal: measures the spacing of edges
`timescale 1ns/1ps
module sofs_load
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic pulse_in,
   output int min_gap,
   output int toggles
);
   logic last_q;
   int run_q;
   // First edge is not timed: its phase to reset is arbitrary
   always @(posedge ref_clk or negedge rst_b)
      if (!rst_b)
      begin
         last_q <= 1'b0;
         run_q <= 0;
         min_gap <= 1000;
         toggles <= 0;
      end
      else
      begin
         last_q <= pulse_in;
         run_q <= (pulse_in != last_q) ? 1 : run_q + 1;
         if (pulse_in != last_q && toggles > 0 && run_q < min_gap)
            min_gap <= run_q;
         if (pulse_in != last_q)
            toggles <= toggles + 1;
      end
endmodule // sofs_load

// ==== tb/sofs_props.sv ====
// Checker for the status output function selector
`timescale 1ns/1ps
module sofs_props
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic drive_running,
   input wire logic output_freq_zero,
   input wire logic fault_stop,
   input wire logic [15:0] analog_input_first,
   input wire logic [15:0] analog_input_second,
   input wire logic freq_at_lower_limit,
   input wire logic open_collector_on,
   input wire logic relay_contacts,
   input wire logic dual_terminal_switch_output,
   input wire logic pulse_train_output,
   input wire logic dual_terminal_pulse_mode
);
   // ----------------------------------------
   // Selector shadows and pulse spacing
   // ----------------------------------------
   logic [15:0] oc_q;
   logic [15:0] rl_q;
   logic last_q;
   int gap_q;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   always_ff @(posedge ref_clk or negedge rst_b)
      if (!rst_b)
      begin
         oc_q <= 16'h0000;
         rl_q <= 16'h0002;
      end
      else if (clk_en && reg_wr && reg_addr == 4'h1 && reg_wdata <= 16'h0026)
         oc_q <= reg_wdata;
      else if (clk_en && reg_wr && reg_addr == 4'h2 && reg_wdata <= 16'h001e)
         rl_q <= reg_wdata;
   // Starts saturated so the first toggle after reset is never judged short
   always_ff @(posedge ref_clk or negedge rst_b)
      if (!rst_b)
      begin
         last_q <= 1'b0;
         gap_q <= 1000;
      end
      else
      begin
         last_q <= pulse_train_output;
         gap_q <= (pulse_train_output != last_q) ? 0 : gap_q + 1;
      end
   a_oc_off_zero: assert property ($past(clk_en) && $past(oc_q) == 16'h0000 |-> !open_collector_on)
      else $error("open collector on with code zero");
   a_oc_running: assert property ($past(clk_en) && $past(oc_q) == 16'h0001
      |-> open_collector_on == $past(drive_running))
      else $error("open collector does not follow running");
   a_relay_fault: assert property ($past(rst_b) && $past(clk_en) && $past(rl_q) == 16'h0002
      |-> relay_contacts == $past(fault_stop))
      else $error("relay does not follow stopping fault");
   a_zero_speed: assert property ($past(clk_en) && $past(oc_q) == 16'h0005
      |-> open_collector_on == $past(drive_running && output_freq_zero))
      else $error("zero speed output wrong");
   a_ai_compare: assert property ($past(clk_en) && $past(oc_q) == 16'h0010
      |-> open_collector_on == $past(analog_input_first > analog_input_second))
      else $error("analogue compare output wrong");
   a_lower_limit: assert property ($past(clk_en) && $past(oc_q) == 16'h0012
      |-> open_collector_on == $past(drive_running && freq_at_lower_limit))
      else $error("lower limit output wrong");
   a_oc_bad_code: assert property ($past(clk_en) && $past(oc_q) > 16'h0012 |-> !open_collector_on)
      else $error("open collector on with unused code");
   a_switch_gated: assert property (dual_terminal_pulse_mode |-> !dual_terminal_switch_output)
      else $error("switch output driven in pulse mode");
   a_pulse_idle: assert property (!dual_terminal_pulse_mode && !$past(dual_terminal_pulse_mode)
      |-> !pulse_train_output)
      else $error("pulse train driven in switch mode");
   a_pulse_rate: assert property (dual_terminal_pulse_mode && $past(dual_terminal_pulse_mode)
      && pulse_train_output != last_q |-> gap_q >= 49)
      else $error("pulse toggles faster than 100 kHz allows");
endmodule // sofs_props
bind sofs_top sofs_props u_props (.ref_clk, .rst_b, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .drive_running,
   .output_freq_zero, .fault_stop, .analog_input_first, .analog_input_second, .freq_at_lower_limit,
   .open_collector_on, .relay_contacts, .dual_terminal_switch_output, .pulse_train_output, .dual_terminal_pulse_mode);
